// >>> core/pin_mux_pkg.sv
// constants and carrier types for the upper port h pin multiplexer
`default_nettype none

package pin_mux_pkg;

    // ========================================
    // register byte offsets on the wishbone slave
    localparam logic [7:0] OFS_PIN_DATA = 8'h00;
    localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] OFS_DIRECTION = 8'h08;
    localparam logic [7:0] OFS_ANALOG_SHARED = 8'h0c;
    localparam logic [7:0] OFS_MUX_CFG = 8'h10;

    // ========================================
    // values after reset
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIRECTION_RST = 8'hff;
    localparam logic [7:0] ANALOG_SELECT_RST = 8'h00;
    localparam logic [7:0] SHARED_DEFAULT_RST = 8'h00;
    localparam logic [7:0] MUX_CFG_RST = 8'h03;

    // ========================================
    // field positions
    localparam int CFG_PWM_REMAP_BIT = 0;
    localparam int CFG_PAR_REMAP_BIT = 1;
    localparam int CFG_TRISTATE_LSB = 2;
    localparam int WDT_ALT_SFR_BIT = 4;
    localparam int UPPER_PIN_LSB = 5;
    localparam int UPPER_PINS = 3;
    localparam int LOWER_PINS = 5;

    // ========================================
    // register decode results
    typedef enum logic [2:0]
    {
        REG_PIN_DATA = 3'b000,
        REG_OUTPUT_LATCH = 3'b001,
        REG_DIRECTION = 3'b010,
        REG_ANALOG_SHARED = 3'b011,
        REG_MUX_CFG = 3'b100,
        REG_NONE = 3'b111
    } reg_sel_t;

    // ========================================
    // carriers
    typedef struct packed
    {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed
    {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed
    {
        logic master;
        logic [2:0] en;
        logic byte_enable;
        logic read_strobe;
        logic write_strobe;
    } par_ctl_t;

    typedef struct packed
    {
        logic shutdown;
        logic [2:0] out;
    } pwm_ctl_t;

endpackage

`default_nettype wire

// >>> core/pin_sync.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none

module pin_sync
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous pins in, settled copy out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed
    {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // first stage feeds only the second
    always_comb
    begin
        state_next.first = async_i;
        state_next.second = state_reg.first;
    end

    // register both stages
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sync_o = state_reg.second;

endmodule

`default_nettype wire

// >>> core/port_h_upper_pin_mux.sv
// pin mux and port registers for the upper three pins of port h
//
// Notes on behaviour
// (RULE1) free pin drives latch when direction is 0, reads Schmitt input when 1
// (RULE2) bit 5 carries the parallel port byte enable output
// (RULE3) analog is the reset default and never blocks digital output
// (RULE4) pwm output beats latch and parallel port on its pin
// (RULE5) pwm pins may float while a pwm shutdown is active
// (RULE6) bit 6 drives the parallel read strobe as master
// (RULE7) external master drives bit 6 read input in slave role, TTL buffered
// (RULE8) bit 7 drives the parallel write strobe as master
// (RULE9) external master drives bit 7 write input in slave role, TTL buffered
// (RULE10) parallel port functions set direction; direction bit ignored
// (RULE11) parallel inputs are TTL buffered, port data inputs Schmitt buffered
// (RULE12) pwm outputs reach these pins only while pwm remap bit is clear
// (RULE13) parallel functions reach these pins only with remap 0 on large package
// (RULE14) small package: data, latch, direction unimplemented, read zero
// (RULE15) analog select reachable only while watchdog control bit 4 is 1
// (RULE16) unit one channel B sits on bit 7 under pwm rules
// (RULE17) analog select bits 7..0 pick mode of channels 15..8
`default_nettype none

module port_h_upper_pin_mux
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone register slave
    input wire pin_mux_pkg::wb_req_t wb_req_i,
    output pin_mux_pkg::wb_rsp_t wb_rsp_o,
    // device configuration
    input wire logic [7:0] watchdog_control_i,
    input wire logic large_package_i,
    // port h pins
    input wire logic [7:0] pin_i,
    output logic [2:0] pin_upper_o,
    output logic [2:0] pin_upper_oe_o,
    // lower pins belong to the neighbouring rows
    output logic [4:0] latch_low_o,
    output logic [4:0] direction_low_o,
    // parallel host port
    input wire pin_mux_pkg::par_ctl_t par_i,
    output logic par_read_in_o,
    output logic par_write_in_o,
    // enhanced pwm units
    input wire pin_mux_pkg::pwm_ctl_t pwm_i,
    output logic pwm_on_port_h_o,
    // analog channels 13 to 15
    output logic [2:0] analog_ch_enable_o
);

    // ========================================
    // state

    typedef struct packed
    {
        logic [7:0] latch;
        logic [7:0] direction;
        logic [7:0] analog_select;
        logic [7:0] shared_default;
        logic [7:0] mux_cfg;
        logic ack;
        logic [31:0] rdata;
        logic [2:0] pin_out;
        logic [2:0] pin_oe;
        logic par_rd_in;
        logic par_wr_in;
    } mux_state_t;

    mux_state_t state_reg;
    mux_state_t state_next;

    logic [7:0] pin_sync;
    logic [7:0] pin_digital;
    logic [2:0] analog_mode;
    logic [2:0] pwm_own;
    logic [2:0] par_own;
    logic [2:0] par_drive;
    logic [2:0] par_value;
    logic [2:0] mux_out;
    logic [2:0] mux_oe;
    logic pwm_routed;
    logic par_routed;
    logic access;
    logic alt_sfr;
    pin_mux_pkg::reg_sel_t rsel;
    logic [7:0] read_byte;

    // ========================================
    // address decode

    function automatic pin_mux_pkg::reg_sel_t decode(input logic [7:0] adr);
        pin_mux_pkg::reg_sel_t sel;
        sel = pin_mux_pkg::REG_NONE;
        unique case (adr)
            pin_mux_pkg::OFS_PIN_DATA: sel = pin_mux_pkg::REG_PIN_DATA;
            pin_mux_pkg::OFS_OUTPUT_LATCH: sel = pin_mux_pkg::REG_OUTPUT_LATCH;
            pin_mux_pkg::OFS_DIRECTION: sel = pin_mux_pkg::REG_DIRECTION;
            pin_mux_pkg::OFS_ANALOG_SHARED: sel = pin_mux_pkg::REG_ANALOG_SHARED;
            pin_mux_pkg::OFS_MUX_CFG: sel = pin_mux_pkg::REG_MUX_CFG;
            default: sel = pin_mux_pkg::REG_NONE;
        endcase
        return sel;
    endfunction

    // ========================================
    // pin input synchroniser

    pin_sync
    #(
        .WIDTH(8)
    )
    u_pin_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(pin_i),
        .sync_o(pin_sync)
    );

    // ========================================
    // routing conditions

    // (RULE12) pwm remap bit clear routes pwm here
    assign pwm_routed = ~state_reg.mux_cfg[pin_mux_pkg::CFG_PWM_REMAP_BIT];
    // (RULE13) parallel port here only on large package with remap 0
    assign par_routed = large_package_i
        & ~state_reg.mux_cfg[pin_mux_pkg::CFG_PAR_REMAP_BIT];
    // (RULE15) shared address view follows watchdog control bit 4
    assign alt_sfr = watchdog_control_i[pin_mux_pkg::WDT_ALT_SFR_BIT];

    // (RULE17) bit 5+i of analog select gives channel 13+i
    assign analog_mode = ~state_reg.analog_select[7:5];

    // (RULE2) byte enable on bit 5, always an output
    assign par_value[0] = par_i.byte_enable;
    assign par_drive[0] = 1'b1;
    // (RULE6) read strobe on bit 6 driven only as master
    assign par_value[1] = par_i.read_strobe;
    assign par_drive[1] = par_i.master;
    // (RULE8) write strobe on bit 7 driven only as master
    assign par_value[2] = par_i.write_strobe;
    assign par_drive[2] = par_i.master;

    // ========================================
    // per pin priority mux

    generate
        for (genvar i = 0; i < pin_mux_pkg::UPPER_PINS; i++)
        begin : g_pin
            localparam int B = pin_mux_pkg::UPPER_PIN_LSB + i;

            assign pwm_own[i] = pwm_routed;
            assign par_own[i] = par_routed & par_i.en[i];

            always_comb
            begin
                // (RULE4) pwm first, then parallel port, then latch
                if (pwm_own[i])
                begin
                    mux_out[i] = pwm_i.out[i];
                    // (RULE5) float during shutdown when enabled
                    mux_oe[i] = ~(pwm_i.shutdown
                        & state_reg.mux_cfg[pin_mux_pkg::CFG_TRISTATE_LSB + i]);
                end
                else if (par_own[i])
                begin
                    // (RULE10) direction bit has no say here
                    mux_out[i] = par_value[i];
                    mux_oe[i] = par_drive[i];
                end
                else
                begin
                    // (RULE1) latch out when direction is 0
                    mux_out[i] = state_reg.latch[B];
                    mux_oe[i] = ~state_reg.direction[B];
                end
            end

            // (RULE11) Schmitt path reads zero in analog mode
            assign pin_digital[B] = pin_sync[B] & ~analog_mode[i];
        end
    endgenerate

    // lower bits pass through; their analog mode lives elsewhere
    assign pin_digital[4:0] = pin_sync[4:0];

    // ========================================
    // register read view

    assign access = wb_req_i.cyc & wb_req_i.stb & ~state_reg.ack;
    assign rsel = decode(wb_req_i.adr);

    always_comb
    begin
        read_byte = 8'h00;
        unique case (rsel)
            pin_mux_pkg::REG_PIN_DATA:
            begin
                // (RULE14) small package reads zero
                read_byte = large_package_i ? pin_digital : 8'h00;
            end
            pin_mux_pkg::REG_OUTPUT_LATCH:
            begin
                read_byte = large_package_i ? state_reg.latch : 8'h00;
            end
            pin_mux_pkg::REG_DIRECTION:
            begin
                read_byte = large_package_i ? state_reg.direction : 8'h00;
            end
            pin_mux_pkg::REG_ANALOG_SHARED:
            begin
                // (RULE15) analog select or the default register
                read_byte = alt_sfr ? state_reg.analog_select : state_reg.shared_default;
            end
            pin_mux_pkg::REG_MUX_CFG:
            begin
                read_byte = state_reg.mux_cfg;
            end
            pin_mux_pkg::REG_NONE:
            begin
                read_byte = 8'h00;
            end
        endcase
    end

    // ========================================
    // next state

    always_comb
    begin
        state_next = state_reg;
        state_next.ack = access;
        // pins settle one cycle after the mux
        state_next.pin_out = mux_out;
        state_next.pin_oe = mux_oe;
        if (!large_package_i)
        begin
            // (RULE14) port absent: pins never driven
            state_next.pin_oe = 3'b000;
        end
        // (RULE7) slave read input from bit 6, TTL path
        state_next.par_rd_in = par_own[1] & ~pwm_own[1] & ~par_i.master
            & pin_sync[pin_mux_pkg::UPPER_PIN_LSB + 1];
        // (RULE9) slave write input from bit 7, TTL path
        state_next.par_wr_in = par_own[2] & ~pwm_own[2] & ~par_i.master
            & pin_sync[pin_mux_pkg::UPPER_PIN_LSB + 2];
        if (access)
        begin
            state_next.rdata = {24'h000000, read_byte};
        end
        // register writes on byte lane 0
        if (access && wb_req_i.we && wb_req_i.sel[0])
        begin
            unique case (rsel)
                pin_mux_pkg::REG_PIN_DATA,
                pin_mux_pkg::REG_OUTPUT_LATCH:
                begin
                    // (RULE14) writes dropped on small package
                    if (large_package_i)
                    begin
                        state_next.latch = wb_req_i.dat[7:0];
                    end
                end
                pin_mux_pkg::REG_DIRECTION:
                begin
                    if (large_package_i)
                    begin
                        state_next.direction = wb_req_i.dat[7:0];
                    end
                end
                pin_mux_pkg::REG_ANALOG_SHARED:
                begin
                    // (RULE15) write lands in the visible register
                    if (alt_sfr)
                    begin
                        state_next.analog_select = wb_req_i.dat[7:0];
                    end
                    else
                    begin
                        state_next.shared_default = wb_req_i.dat[7:0];
                    end
                end
                pin_mux_pkg::REG_MUX_CFG:
                begin
                    state_next.mux_cfg = {3'h0, wb_req_i.dat[4:0]};
                end
                pin_mux_pkg::REG_NONE:
                begin
                    state_next.mux_cfg = state_reg.mux_cfg;
                end
            endcase
        end
    end

    // ========================================
    // state register

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg.latch <= pin_mux_pkg::LATCH_RST;
            state_reg.direction <= pin_mux_pkg::DIRECTION_RST;
            // (RULE3) analog on all channels after reset
            state_reg.analog_select <= pin_mux_pkg::ANALOG_SELECT_RST;
            state_reg.shared_default <= pin_mux_pkg::SHARED_DEFAULT_RST;
            state_reg.mux_cfg <= pin_mux_pkg::MUX_CFG_RST;
            state_reg.ack <= 1'b0;
            state_reg.rdata <= 32'h00000000;
            state_reg.pin_out <= 3'h0;
            state_reg.pin_oe <= 3'h0;
            state_reg.par_rd_in <= 1'b0;
            state_reg.par_wr_in <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ========================================
    // outputs

    assign wb_rsp_o.ack = state_reg.ack;
    assign wb_rsp_o.dat = state_reg.rdata;
    // (RULE3) analog mode leaves the output path alone
    assign pin_upper_o = state_reg.pin_out;
    // (RULE16) bit 7 carries unit one channel B via the same mux
    assign pin_upper_oe_o = state_reg.pin_oe;
    assign latch_low_o = state_reg.latch[4:0];
    assign direction_low_o = state_reg.direction[4:0];
    assign par_read_in_o = state_reg.par_rd_in;
    assign par_write_in_o = state_reg.par_wr_in;
    // (RULE12) tells the other port the pwm outputs left it
    assign pwm_on_port_h_o = pwm_routed;
    assign analog_ch_enable_o = analog_mode;

endmodule

`default_nettype wire

// >>> test/port_h_far_side.sv
// far side model: external parallel master and loads on port h
`default_nettype none

module port_h_far_side
(
    // clock
    input wire logic clk_i,
    // device and external drive of pins 7..5
    input wire logic [2:0] dev_val_i,
    input wire logic [2:0] dev_en_i,
    input wire logic [2:0] ext_val_i,
    input wire logic [2:0] ext_en_i,
    // resolved port h levels, lower rows idle low
    output logic [7:0] pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] float_reg = 3'h2;

    // undriven pins have no keeper: level changes every cycle
    always_ff @(posedge clk_i)
        float_reg <= ~float_reg;

    always_comb
    begin
        pin_o = 8'h00;
        for (int i = 0; i < 3; i++)
            pin_o[5 + i] = dev_en_i[i] ? dev_val_i[i]
                : (ext_en_i[i] ? ext_val_i[i] : float_reg[i]);
    end
endmodule

`default_nettype wire

// >>> test/port_h_upper_pin_mux_properties.sv
// assertion checker for the port h upper pin mux
`default_nettype none

module port_h_upper_pin_mux_properties
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus and package
    input wire pin_mux_pkg::wb_req_t wb_req_i,
    input wire pin_mux_pkg::wb_rsp_t wb_rsp_o,
    input wire logic large_package_i,
    // pin drive and its sources
    input wire logic [2:0] pin_upper_o,
    input wire logic [2:0] pin_upper_oe_o,
    input wire pin_mux_pkg::par_ctl_t par_i,
    input wire pin_mux_pkg::pwm_ctl_t pwm_i
);
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed
    {
        logic [1:0] age;
        logic [7:0] cfg;
    } shadow_t;
    shadow_t s_reg;
    shadow_t s_next;
    logic take;
    logic wcfg;
    logic ok;

    // ========================================
    // cycles since reset and a copy of the mux config
    assign take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    assign wcfg = take && wb_req_i.we && wb_req_i.sel[0]
        && wb_req_i.adr == pin_mux_pkg::OFS_MUX_CFG;
    assign ok = s_reg.age == 2'h3;
    always_comb
    begin
        s_next = s_reg;
        if (s_reg.age != 2'h3)
            s_next.age = s_reg.age + 2'h1;
        if (wcfg)
            s_next.cfg = wb_req_i.dat[7:0];
        if (rst_i)
            s_next = {2'h0, pin_mux_pkg::MUX_CFG_RST};
    end
    always_ff @(posedge clk_i)
        s_reg <= s_next;

    // ========================================
    // bus answer and pin mux relations
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; take |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not one cycle");
    property p_ack_cause; wb_rsp_o.ack |-> $past(take); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_hi_zero; wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
    property p_small_read; take && !wb_req_i.we && !large_package_i
        && wb_req_i.adr <= pin_mux_pkg::OFS_DIRECTION |=> wb_rsp_o.dat == 32'h0; endproperty
    a_small_read: assert property (p_small_read) else $error("small read not 0");
    property p_small_float; ok && !$past(large_package_i) |-> pin_upper_oe_o == 3'h0; endproperty
    a_small_float: assert property (p_small_float) else $error("small drives");
    property p_pwm_drive; ok && $past(large_package_i) && !$past(s_reg.cfg[0])
        |-> (pin_upper_o & pin_upper_oe_o) == ($past(pwm_i.out) & pin_upper_oe_o); endproperty
    a_pwm_drive: assert property (p_pwm_drive) else $error("pwm not on pin");
    property p_pwm_float; ok && $past(large_package_i) && !$past(s_reg.cfg[0])
        |-> pin_upper_oe_o == ~({3{$past(pwm_i.shutdown)}} & $past(s_reg.cfg[4:2]));
    endproperty
    a_pwm_float: assert property (p_pwm_float) else $error("pwm enable wrong");
    property p_par_master; ok && $past(large_package_i) && $past(s_reg.cfg[1:0]) == 2'b01
        && $past(par_i.master) && $past(par_i.en) == 3'h7 |-> pin_upper_oe_o == 3'h7
        && pin_upper_o == {$past(par_i.write_strobe), $past(par_i.read_strobe),
        $past(par_i.byte_enable)}; endproperty
    a_par_master: assert property (p_par_master) else $error("strobe wrong");
    c_shutdown: cover property (ok && pwm_i.shutdown && !s_reg.cfg[0]);
    c_master: cover property (ok && par_i.master && s_reg.cfg[1:0] == 2'b01);
    c_small: cover property (take && !large_package_i);
endmodule

bind port_h_upper_pin_mux port_h_upper_pin_mux_properties port_h_upper_pin_mux_properties_i
(
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .large_package_i(large_package_i), .pin_upper_o(pin_upper_o),
    .pin_upper_oe_o(pin_upper_oe_o), .par_i(par_i), .pwm_i(pwm_i)
);

`default_nettype wire

// >>> test/port_h_upper_pin_mux_test.sv
// self-checking bench for the port h upper pin mux
`default_nettype none

module port_h_upper_pin_mux_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    pin_mux_pkg::wb_req_t req = '0;
    pin_mux_pkg::wb_rsp_t rsp;
    pin_mux_pkg::par_ctl_t par = '0;
    pin_mux_pkg::pwm_ctl_t pwm = '0;
    logic [7:0] wdt = 8'h00;
    logic big = 1'b1;
    logic [2:0] xv = 3'h0;
    logic [2:0] xe = 3'h0;
    logic [2:0] po, poe, ana;
    logic [4:0] llo, dlo;
    logic [7:0] pin;
    logic rdi, wri, pon;
    int n_fail = 0;
    int checked = 0;

    always #12.5 clk_i = ~clk_i;

    port_h_upper_pin_mux port_h_upper_pin_mux_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(req), .wb_rsp_o(rsp), .watchdog_control_i(wdt), .large_package_i(big),
        .pin_i(pin), .pin_upper_o(po), .pin_upper_oe_o(poe), .latch_low_o(llo),
        .direction_low_o(dlo), .par_i(par), .par_read_in_o(rdi), .par_write_in_o(wri),
        .pwm_i(pwm), .pwm_on_port_h_o(pon), .analog_ch_enable_o(ana));
    port_h_far_side port_h_far_side_i (.clk_i(clk_i), .dev_val_i(po), .dev_en_i(poe),
        .ext_val_i(xv), .ext_en_i(xe), .pin_o(pin));

    // ========================================
    // shared helpers
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            n_fail++;
            $display("Error at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (rsp.ack !== 1'b1);
        q = rsp.dat;
        // ack one cycle after the taking edge
        chk(n, 32'h2);
        req <= '0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, {24'h0, e});
    endtask

    // ========================================
    // scenarios
    task t_reset;
        rdc(pin_mux_pkg::OFS_OUTPUT_LATCH, pin_mux_pkg::LATCH_RST);
        rdc(pin_mux_pkg::OFS_DIRECTION, pin_mux_pkg::DIRECTION_RST);
        rdc(pin_mux_pkg::OFS_MUX_CFG, pin_mux_pkg::MUX_CFG_RST);
        chk({29'h0, ana}, 32'h7);
        chk({24'h0, poe, dlo}, 32'h1f);
        wr(8'h14, 8'hff);
        rdc(8'h14, 8'h00);
    endtask
    task t_latch;
        wr(pin_mux_pkg::OFS_OUTPUT_LATCH, 8'ha5);
        wr(pin_mux_pkg::OFS_DIRECTION, 8'h00);
        tick(2);
        chk({26'h0, po, poe}, {26'h0, 3'b101, 3'b111});
        chk({22'h0, llo, dlo}, {22'h0, 5'h05, 5'h00});
        wr(pin_mux_pkg::OFS_DIRECTION, 8'hff);
        xe <= 3'h7;
        xv <= 3'b011;
        tick(4);
        chk({29'h0, poe}, 32'h0);
        rdc(pin_mux_pkg::OFS_PIN_DATA, 8'h00);
        wdt <= 8'h10;
        wr(pin_mux_pkg::OFS_ANALOG_SHARED, 8'he0);
        tick(2);
        chk({29'h0, ana}, 32'h0);
        rdc(pin_mux_pkg::OFS_PIN_DATA, 8'h60);
        xe <= 3'h0;
    endtask
    task t_shared;
        wdt <= 8'hef;
        wr(pin_mux_pkg::OFS_ANALOG_SHARED, 8'h5a);
        rdc(pin_mux_pkg::OFS_ANALOG_SHARED, 8'h5a);
        wdt <= 8'h10;
        rdc(pin_mux_pkg::OFS_ANALOG_SHARED, 8'he0);
        wr(pin_mux_pkg::OFS_ANALOG_SHARED, 8'h40);
        tick(2);
        chk({29'h0, ana}, 32'h5);
    endtask
    task t_pwm;
        wr(pin_mux_pkg::OFS_DIRECTION, 8'h00);
        pwm <= '{1'b0, 3'b010};
        wr(pin_mux_pkg::OFS_MUX_CFG, 8'h16);
        tick(2);
        chk({26'h0, po, poe}, {26'h0, 3'b010, 3'b111});
        chk({31'h0, pon}, 32'h1);
        pwm <= '{1'b1, 3'b111};
        tick(2);
        chk({26'h0, po & poe, poe}, {26'h0, 3'b010, 3'b010});
        wr(pin_mux_pkg::OFS_PIN_DATA, 8'h4a);
        wr(pin_mux_pkg::OFS_MUX_CFG, 8'h17);
        tick(2);
        chk({25'h0, po, poe, pon}, {25'h0, 3'b010, 3'b111, 1'b0});
    endtask
    task t_par;
        wr(pin_mux_pkg::OFS_DIRECTION, 8'hff);
        par <= '{1'b1, 3'h7, 1'b0, 1'b1, 1'b0};
        wr(pin_mux_pkg::OFS_MUX_CFG, 8'h01);
        tick(2);
        chk({26'h0, po, poe}, {26'h0, 3'b010, 3'b111});
        par <= '{1'b1, 3'h7, 1'b1, 1'b1, 1'b1};
        tick(2);
        chk({26'h0, po, poe}, {26'h0, 3'b111, 3'b111});
        wr(pin_mux_pkg::OFS_MUX_CFG, 8'h03);
        tick(2);
        chk({29'h0, poe}, 32'h0);
        wr(pin_mux_pkg::OFS_MUX_CFG, 8'h01);
        big <= 1'b0;
        tick(2);
        chk({29'h0, poe}, 32'h0);
        rdc(pin_mux_pkg::OFS_OUTPUT_LATCH, 8'h00);
        wr(pin_mux_pkg::OFS_DIRECTION, 8'h00);
        big <= 1'b1;
        rdc(pin_mux_pkg::OFS_DIRECTION, 8'hff);
    endtask
    task t_slave;
        par <= '{1'b0, 3'b110, 1'b0, 1'b0, 1'b0};
        xe <= 3'b110;
        xv <= 3'b100;
        tick(5);
        chk({27'h0, rdi, wri, poe}, 32'h8);
        xv <= 3'b010;
        tick(5);
        chk({27'h0, rdi, wri, poe}, 32'h10);
        xe <= 3'h0;
    endtask

    // ========================================
    // verdict, watchdog and main sequence
    task wrap_up;
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        tick(4000);
        n_fail++;
        wrap_up();
    end
    initial
    begin
        tick(5);
        rst_i <= 1'b0;
        t_reset();
        t_latch();
        t_shared();
        t_pwm();
        t_par();
        t_slave();
        wrap_up();
    end
endmodule

`default_nettype wire
